// *** hw/ofs_top.v ***
// Operand fetch sequencer: fetch, decode, A and C forks, branches
`timescale 1ns/1ps
`include "ofs_regs.vh"
module ofs_top (
  input wire core_clk,
  input wire sys_rst,
  input wire overlap_start,
  input wire brk_request,
  input wire fp_present,
  input wire is_binary,
  input wire is_single,
  input wire is_float,
  input wire is_mtp,
  input wire is_branch,
  input wire branch_taken,
  input wire [15:0] branch_disp,
  input wire [15:0] bus_data,
  input wire bus_done,
  input wire [15:0] gs_data,
  input wire [15:0] gd_data,
  input wire [15:0] stack_ptr,
  output reg bus_start,
  output reg bus_end_abort,
  output reg [15:0] bus_addr,
  output reg [2:0] microcode_bus_control_field,
  output reg [15:0] instruction_register,
  output reg [15:0] bus_register,
  output reg [15:0] program_counter_copy,
  output reg [15:0] source_operand_register,
  output reg [15:0] destination_operand_register,
  output reg [15:0] coprocessor_address_register,
  output reg [15:0] coprocessor_instruction_register,
  output reg [2:0] gs_sel,
  output reg [2:0] gd_sel,
  output reg request_capture_strobe,
  output reg break_entry,
  output reg execute_go,
  output reg [3:0] tstate
);
  // One-hot machine states
  localparam [15:0] ST_FET0 = 16'h0001; // fetch_start_state
  localparam [15:0] ST_FET1 = 16'h0002; // fetch_complete_state
  localparam [15:0] ST_IRD = 16'h0004; // decode_state
  localparam [15:0] ST_SRC0 = 16'h0008; // post-decode source entry
  localparam [15:0] ST_S45 = 16'h0010; // autodecrement_source_state
  localparam [15:0] ST_S67 = 16'h0020; // index_word_source_state
  localparam [15:0] ST_SBUS = 16'h0040; // source pause
  localparam [15:0] ST_SIND = 16'h0080; // deferred source pause
  localparam [15:0] ST_DST0 = 16'h0100; // destination entry
  localparam [15:0] ST_DBUS = 16'h0200; // destination pause
  localparam [15:0] ST_MTP0 = 16'h0400; // read stack pointer
  localparam [15:0] ST_MTP1 = 16'h0800; // start data fetch
  localparam [15:0] ST_BXX = 16'h1000; // taken_branch_state
  localparam [15:0] ST_EXEC = 16'h2000; // hand to execute fork
  localparam [15:0] ST_BRK = 16'h4000; // break_entry_state
  localparam [15:0] ST_DPAUSE = 16'h8000; // decode pause / abort

  // Cycles per machine state: 60 ns time state over 40 ns clock, up
  localparam integer TS_CYC_N = (`OFS_TSTATE_NS + `OFS_CLK_NS - 1) /
    `OFS_CLK_NS;
  localparam [3:0] TS_CYC = TS_CYC_N[3:0];

  wire [2:0] sm, dm, sf, df;
  wire bin_sm0, dm0, sm123, sm45, sm67, dm123, dac;
  reg [15:0] state, next_state;
  reg [3:0] phase;
  reg brq_s1, brq_s2, brq_held;
  reg next_bus_start, next_abort;
  reg [2:0] next_field;
  reg [15:0] next_addr;
  reg src_odd, c_fork, ird_bus_start_live;
  wire step;

  ofs_mode_decode u_dec (
    .instr(instruction_register),
    .is_binary(is_binary),
    .is_single(is_single),
    .is_float(is_float),
    .is_mtp(is_mtp),
    .source_mode_field(sm),
    .destination_mode_field(dm),
    .src_field(sf),
    .dst_field(df),
    .bin_sm0(bin_sm0),
    .dm0(dm0),
    .sm123(sm123),
    .sm45(sm45),
    .sm67(sm67),
    .dm123(dm123),
    .dac(dac)
  );

  // Conditional bus start gating: top gate and branch term low to assert; both mode terms must be low too unless sm67 with dm123
  function cond_bus_start;
    input [2:0] field;
    input sm123_i, branch_i, brq_i, dac_i, dm123_i, sm67_i;
    reg top_gate, g2, g3, g4, keep;
    begin
      top_gate = !((field == `OFS_COND_BUS_START) ||
        (field == `OFS_BUS_ALT));
      g2 = (field == `OFS_COND_BUS_START) && sm123_i;
      g3 = (field == `OFS_COND_BUS_START) && branch_i && brq_i;
      g4 = (field == `OFS_COND_BUS_START) && dac_i && dm123_i;
      keep = sm67_i && dm123_i;
      cond_bus_start = !top_gate && !g3 && (keep || (!g2 && !g4));
    end
  endfunction

  // Machine state advances once per time state window
  assign step = (phase == TS_CYC - 4'h1);

  // Asynchronous request pin through two flops
  always @(posedge core_clk) begin
    if (sys_rst) begin
      brq_s1 <= 1'b0;
      brq_s2 <= 1'b0;
    end else begin
      brq_s1 <= brk_request;
      brq_s2 <= brq_s1;
    end
  end

  // Next-state and bus control decode
  always @* begin
    next_state = state;
    next_bus_start = 1'b0;
    next_abort = 1'b0;
    next_field = 3'h0;
    next_addr = bus_addr;
    case (state)
      ST_FET0: begin
        // Fetch start checks pending requests first
        if (brq_held) begin
          next_state = ST_BRK;
        end else begin
          next_bus_start = 1'b1;
          next_addr = program_counter_copy;
          next_state = ST_FET1;
        end
      end
      ST_FET1: begin
        if (bus_done) begin
          next_state = ST_IRD;
          next_field = `OFS_COND_BUS_START;
        end
      end
      ST_IRD: begin
        // Decode starts read at PC unless gated off
        next_addr = program_counter_copy;
        next_bus_start = cond_bus_start(microcode_bus_control_field, sm123,
          is_branch, brq_held, dac, dm123, sm67);
        if (is_branch && branch_taken) begin
          next_state = ST_BXX;
        end else if (is_branch) begin
          next_state = brq_held ? ST_FET0 : ST_FET1;
        end else if (is_mtp) begin
          next_state = ST_MTP0;
        end else if (is_binary && !bin_sm0) begin
          next_state = sm67 ? ST_S67 : ST_SRC0;
        end else if (is_float && !dm0) begin
          next_state = ST_DST0;
        end else if (dac && !dm0) begin
          next_state = ST_DST0;
        end else begin
          next_state = ST_EXEC;
        end
        if (next_state == ST_FET0) begin
          next_bus_start = 1'b0;
        end
      end
      ST_SRC0: begin
        // Source entry: modes 1-3 restart, 4-5 abort first
        if (sm45) begin
          next_abort = 1'b1;
          next_state = ST_S45;
        end else begin
          next_abort = ird_bus_start_live;
          next_bus_start = 1'b1;
          next_addr = gs_data;
          next_state = ST_SBUS;
        end
      end
      ST_S45: begin
        // Start only after address decremented
        next_bus_start = 1'b1;
        next_addr = source_operand_register - `OFS_PC_STEP;
        next_state = ST_SBUS;
      end
      ST_S67: begin
        // Index word completes decode transfer at PC
        if (bus_done) begin
          next_bus_start = 1'b1;
          next_addr = bus_data + gs_data;
          next_state = ST_SBUS;
        end
      end
      ST_SBUS: begin
        if (bus_done) begin
          if (src_odd) begin
            next_bus_start = 1'b1;
            next_addr = bus_data;
            next_state = ST_SIND;
          end else begin
            next_state = c_fork ? ST_DST0 : ST_EXEC;
          end
        end
      end
      ST_SIND: next_state = !bus_done ? ST_SIND :
        (c_fork ? ST_DST0 : ST_EXEC);
      ST_DST0: begin
        next_abort = ird_bus_start_live;
        next_bus_start = 1'b1;
        next_addr = gd_data;
        next_state = ST_DBUS;
      end
      ST_DBUS: next_state = bus_done ? ST_EXEC : ST_DBUS;
      ST_MTP0: begin
        // Abort decode read, address from stack pointer
        next_abort = ird_bus_start_live;
        next_addr = stack_ptr;
        next_state = ST_MTP1;
      end
      ST_MTP1: begin
        next_bus_start = 1'b1;
        next_state = ST_SIND;
      end
      ST_BXX: begin
        next_abort = 1'b1;
        next_state = ST_FET0;
      end
      ST_EXEC: begin
        // Overlapped fetch: starting state checks requests
        if (overlap_start && !brq_held) begin
          next_bus_start = 1'b1;
          next_addr = program_counter_copy;
          next_state = ST_FET1;
        end else begin
          next_abort = ird_bus_start_live;
          next_state = ST_FET0;
        end
      end
      ST_BRK: next_state = brq_held ? ST_BRK : ST_FET0;
      default: next_state = ST_FET0;
    endcase
  end

  // State register, datapath loads and outputs
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_FET0;
      phase <= 4'h0;
      tstate <= 4'h1;
      brq_held <= 1'b0;
      bus_start <= 1'b0;
      bus_end_abort <= 1'b0;
      bus_addr <= `OFS_WORD_RESET;
      microcode_bus_control_field <= 3'h0;
      instruction_register <= `OFS_WORD_RESET;
      bus_register <= `OFS_WORD_RESET;
      program_counter_copy <= `OFS_WORD_RESET;
      source_operand_register <= `OFS_WORD_RESET;
      destination_operand_register <= `OFS_WORD_RESET;
      coprocessor_address_register <= `OFS_WORD_RESET;
      coprocessor_instruction_register <= `OFS_WORD_RESET;
      gs_sel <= 3'h0;
      gd_sel <= 3'h0;
      request_capture_strobe <= 1'b0;
      break_entry <= 1'b0;
      execute_go <= 1'b0;
      src_odd <= 1'b0;
      c_fork <= 1'b0;
      ird_bus_start_live <= 1'b0;
    end else begin
      // Pulses default low; asserted for one clock only
      bus_start <= 1'b0;
      bus_end_abort <= 1'b0;
      request_capture_strobe <= 1'b0;
      break_entry <= 1'b0;
      execute_go <= 1'b0;
      phase <= step ? 4'h0 : phase + 4'h1;
      tstate <= step ? 4'h1 : {tstate[2:0], 1'b0};
      gs_sel <= sf;
      gd_sel <= df;
      if (step) begin
        state <= next_state;
        bus_start <= next_bus_start;
        bus_end_abort <= next_abort;
        bus_addr <= next_addr;
        microcode_bus_control_field <= next_field;
        if (state == ST_FET1 && bus_done) begin
          instruction_register <= bus_data;
          bus_register <= bus_data;
          program_counter_copy <= program_counter_copy +
            `OFS_PC_STEP;
          request_capture_strobe <= 1'b1;
          if (fp_present) begin
            coprocessor_address_register <= bus_addr;
          end
        end
        if (state == ST_IRD) begin
          ird_bus_start_live <= next_bus_start;
          src_odd <= sm[0];
          c_fork <= ((is_binary && !bin_sm0) || is_float) && !dm0;
          if (fp_present) begin
            coprocessor_instruction_register <= bus_register;
          end
        end else if (next_abort || state == ST_S67) begin
          ird_bus_start_live <= 1'b0;
        end
        if (state == ST_SRC0 || state == ST_DST0 ||
            state == ST_MTP0) begin
          // Anticipatory register loads
          source_operand_register <= gs_data;
          destination_operand_register <= gd_data;
        end
        if (state == ST_SRC0 && sm != 3'h1 && !sm45) begin
          source_operand_register <= gs_data + `OFS_PC_STEP;
        end
        if (state == ST_S45) begin
          source_operand_register <= source_operand_register -
            `OFS_PC_STEP;
        end
        if ((state == ST_SBUS || state == ST_SIND) && bus_done) begin
          bus_register <= bus_data;
        end
        if (state == ST_BXX) begin
          program_counter_copy <= program_counter_copy +
            branch_disp;
          request_capture_strobe <= 1'b1;
        end
        execute_go <= (state == ST_EXEC);
        break_entry <= (next_state == ST_BRK) && (state != ST_BRK);
      end
      // Requests latched on capture strobe or while in the break state
      if (request_capture_strobe || state == ST_BRK) begin
        brq_held <= brq_s2;
      end
    end
  end
endmodule

// *** pkg/ofs_regs.vh ***
// Constants for the operand fetch sequencer
`ifndef OFS_REGS_VH
`define OFS_REGS_VH
`define OFS_SM_HI 11
`define OFS_SM_LO 9
`define OFS_SF_HI 8
`define OFS_SF_LO 6
`define OFS_DM_HI 5
`define OFS_DM_LO 3
`define OFS_DF_HI 2
`define OFS_DF_LO 0
`define OFS_PC_STEP 16'h0002
`define OFS_COND_BUS_START 3'h5
`define OFS_BUS_ALT 3'h7
`define OFS_PULSE_NS 15
`define OFS_PULSE_PERIOD_NS 30
`define OFS_TSTATE_NS 60
`define OFS_CLK_NS 40
`define OFS_WORD_RESET 16'h0000
`endif

// *** hw/ofs_mode_decode.v ***
// Instruction class and addressing mode decoder
`timescale 1ns/1ps
`include "ofs_regs.vh"
module ofs_mode_decode (
  input wire [15:0] instr,
  input wire is_binary,
  input wire is_single,
  input wire is_float,
  input wire is_mtp,
  output wire [2:0] source_mode_field,
  output wire [2:0] destination_mode_field,
  output wire [2:0] src_field,
  output wire [2:0] dst_field,
  output wire bin_sm0,
  output wire dm0,
  output wire sm123,
  output wire sm45,
  output wire sm67,
  output wire dm123,
  output wire dac
);
  // Mode and register fields
  assign source_mode_field = instr[`OFS_SM_HI:`OFS_SM_LO];
  assign destination_mode_field = instr[`OFS_DM_HI:`OFS_DM_LO];
  assign src_field = instr[`OFS_SF_HI:`OFS_SF_LO];
  assign dst_field = instr[`OFS_DF_HI:`OFS_DF_LO];
  // Class predicates used by the forks
  assign bin_sm0 = is_binary && (source_mode_field == 3'h0);
  assign dm0 = (destination_mode_field == 3'h0);
  assign sm123 = is_binary && (source_mode_field >= 3'h1) &&
    (source_mode_field <= 3'h3);
  assign sm45 = is_binary && ((source_mode_field == 3'h4) ||
    (source_mode_field == 3'h5));
  assign sm67 = is_binary && (source_mode_field[2:1] == 2'b11);
  assign dm123 = (destination_mode_field >= 3'h1) &&
    (destination_mode_field <= 3'h3);
  // Destination address calculation class (mtp excluded)
  assign dac = (bin_sm0 || is_single) && !is_mtp && !is_float;
endmodule

// *** tb/ofs_checker_assertions.sv ***
// Port checker for the operand fetch sequencer
`timescale 1ns/1ps
module ofs_checker (
  input wire core_clk,
  input wire sys_rst,
  input wire brk_request,
  input wire fp_present,
  input wire bus_start,
  input wire bus_end_abort,
  input wire [15:0] bus_addr,
  input wire [15:0] instruction_register,
  input wire [15:0] bus_register,
  input wire [15:0] program_counter_copy,
  input wire [15:0] coprocessor_address_register,
  input wire [2:0] gs_sel,
  input wire [2:0] gd_sel,
  input wire request_capture_strobe,
  input wire break_entry,
  input wire execute_go,
  input wire [3:0] tstate
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  reg [4:0] brk_age;
  // Age of last break request; saturates so it never wraps back to zero
  always @(posedge core_clk) begin
    if (sys_rst || brk_request) brk_age <= 5'h00;
    else if (brk_age != 5'h1f) brk_age <= brk_age + 5'h01;
  end
  chk_start_pulse: assert property (bus_start |=> !bus_start)
    else $error("bus start held past one clock");
  chk_abort_pulse: assert property (bus_end_abort |=> !bus_end_abort)
    else $error("bus end held past one clock");
  chk_fetch_load: assert property ($changed(instruction_register) |->
    bus_register == instruction_register &&
    program_counter_copy == $past(program_counter_copy) + 16'h0002)
    else $error("fetch did not load both words and step the counter");
  chk_first_fetch: assert property ($fell(sys_rst) |->
    ##[1:6] (bus_start && bus_addr == 16'h0000))
    else $error("no fetch start at address zero after reset");
  chk_one_phase: assert property ($onehot(tstate))
    else $error("phase not one-hot");
  chk_reg_select: assert property ($changed(instruction_register) |->
    ##[0:4] (gs_sel == instruction_register[8:6] &&
    gd_sel == instruction_register[2:0]))
    else $error("register selects do not follow the instruction");
  chk_break_cause: assert property (break_entry |-> brk_age < 5'h10)
    else $error("break entered with no recent request");
  chk_fp_absent: assert property (!fp_present && !$past(fp_present) |->
    $stable(coprocessor_address_register))
    else $error("coprocessor address moved without the option");
  cover property (bus_end_abort);
  cover property (break_entry);
  cover property (execute_go);
  cover property (request_capture_strobe);
endmodule

bind ofs_top ofs_checker i_ofs_checker (.core_clk, .sys_rst, .brk_request,
  .fp_present, .bus_start, .bus_end_abort, .bus_addr,
  .instruction_register, .bus_register, .program_counter_copy,
  .coprocessor_address_register, .gs_sel, .gd_sel,
  .request_capture_strobe, .break_entry, .execute_go, .tstate);

// *** tb/ofs_mem_model.sv ***
// Memory model answering the sequencer's bus transfers
`timescale 1ns/1ps
module ofs_mem_model (
  input wire core_clk,
  input wire sys_rst,
  input wire slow,
  input wire [15:0] prog_word,
  input wire bus_start,
  input wire bus_end_abort,
  input wire [15:0] bus_addr,
  output reg [15:0] bus_data,
  output reg bus_done
);
  reg [3:0] wait_cnt;
  reg [2:0] hold_cnt;
  reg busy;
  reg [15:0] addr;
  initial begin
    bus_data = 16'hffff;
    bus_done = 1'b0;
    busy = 1'b0;
    wait_cnt = 4'h0;
    hold_cnt = 3'h0;
    addr = 16'h0000;
  end
  // Low page holds the program, the rest answers with a fixed pointer
  always @(posedge core_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      bus_done <= 1'b0;
    end else if (bus_start) begin
      busy <= 1'b1;
      addr <= bus_addr;
      wait_cnt <= slow ? 4'h7 : 4'h1;
      bus_done <= 1'b0;
    end else if (bus_end_abort) begin
      busy <= 1'b0;
      bus_done <= 1'b0;
    end else if (busy && wait_cnt == 4'h0) begin
      busy <= 1'b0;
      bus_done <= 1'b1;
      hold_cnt <= 3'h3;
      bus_data <= (addr < 16'h0010) ? prog_word : 16'h0040;
    end else if (busy) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (bus_done) begin
      hold_cnt <= hold_cnt - 3'h1;
      if (hold_cnt == 3'h0) bus_done <= 1'b0;
    end else begin
      // Released data toggles so stale words never look valid
      bus_data <= ~bus_data;
    end
  end
endmodule

// *** tb/ofs_top_tb_top.sv ***
// Self-checking bench for the operand fetch sequencer
`timescale 1ns/1ps
module ofs_top_tb_top;
  reg core_clk, sys_rst, brk_request, fp_present, slow, mon, overlap_start;
  reg is_binary, is_single, is_float, is_mtp, is_branch, branch_taken;
  reg [15:0] prog_word;
  reg [7:0] seen;
  reg [39:0] rows [0:14];
  wire bus_start, bus_end_abort, bus_done;
  wire [15:0] bus_addr, bus_data;
  integer fails, tests_run, i, k;
  ofs_top i_ofs_top (.core_clk, .sys_rst, .overlap_start,
    .brk_request, .fp_present, .is_binary, .is_single, .is_float,
    .is_mtp, .is_branch, .branch_taken, .branch_disp(16'h0020),
    .bus_data, .bus_done, .gs_data(16'h0100), .gd_data(16'h0200),
    .stack_ptr(16'h0300), .bus_start, .bus_end_abort, .bus_addr,
    .microcode_bus_control_field(), .instruction_register(),
    .bus_register(), .program_counter_copy(),
    .source_operand_register(), .destination_operand_register(),
    .coprocessor_address_register(),
    .coprocessor_instruction_register(), .gs_sel(), .gd_sel(),
    .request_capture_strobe(), .break_entry(), .execute_go(),
    .tstate());
  ofs_mem_model i_ofs_mem_model (.core_clk, .sys_rst, .slow, .prog_word,
    .bus_start, .bus_end_abort, .bus_addr, .bus_data, .bus_done);
  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Flags: exec, src, dst, pointer, abort, stack, break, branch target
  always @(posedge core_clk) begin
    if (mon) begin
      if (i_ofs_top.execute_go) seen[7] <= 1'b1;
      if (bus_start && bus_addr == 16'h0100) seen[6] <= 1'b1;
      if (bus_start && bus_addr == 16'h0200) seen[5] <= 1'b1;
      if (bus_start && bus_addr == 16'h0040) seen[4] <= 1'b1;
      if (bus_end_abort) seen[3] <= 1'b1;
      if (bus_start && bus_addr == 16'h0300) seen[2] <= 1'b1;
      if (i_ofs_top.break_entry) seen[1] <= 1'b1;
      if (bus_start && bus_addr == 16'h0022) seen[0] <= 1'b1;
    end
  end
  task chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Reset for five clocks with the row's inputs already applied
  task start_run(input [39:0] r);
    begin
      @(posedge core_clk);
      sys_rst <= 1'b1;
      mon <= 1'b0;
      seen <= 8'h00;
      {prog_word, is_binary, is_single, is_float, is_mtp} <= r[39:20];
      {is_branch, branch_taken, brk_request, slow} <= r[19:16];
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      mon <= 1'b1;
    end
  endtask
  task wrap_up;
    begin
      if (fails == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    fails = fails + 1;
    wrap_up;
  end
  initial begin
    {sys_rst, brk_request, fp_present, slow, mon} = 5'h11;
    {is_binary, is_single, is_float, is_mtp} = 4'h0;
    {is_branch, branch_taken} = 2'h0;
    overlap_start = 1'b0;
    prog_word = 16'h0000;
    seen = 8'h00;
    fails = 0;
    tests_run = 0;
    // Word, class, control, expected flags, flags that matter
    rows[0] = {16'h1042, 5'h10, 3'h0, 8'h88, 8'hf8};
    rows[1] = {16'h1242, 5'h10, 3'h0, 8'h50, 8'h70};
    rows[2] = {16'h1642, 5'h10, 3'h0, 8'h50, 8'h50};
    rows[3] = {16'h1842, 5'h10, 3'h0, 8'h08, 8'h48};
    rows[4] = {16'h104a, 5'h10, 3'h0, 8'h20, 8'h60};
    rows[5] = {16'h124a, 5'h10, 3'h0, 8'h60, 8'h60};
    rows[6] = {16'h0a02, 5'h08, 3'h0, 8'h80, 8'he0};
    rows[7] = {16'h0a0a, 5'h08, 3'h0, 8'h20, 8'h60};
    rows[8] = {16'hf20a, 5'h04, 3'h0, 8'h20, 8'h20};
    rows[9] = {16'h6a0a, 5'h02, 3'h0, 8'h04, 8'h04};
    rows[10] = {16'h0104, 5'h01, 3'h4, 8'h01, 8'h03};
    rows[11] = {16'h0104, 5'h01, 3'h2, 8'h02, 8'h03};
    rows[12] = {16'h1042, 5'h10, 3'h2, 8'h02, 8'h02};
    rows[13] = {16'h1242, 5'h10, 3'h1, 8'h50, 8'h70};
    rows[14] = {16'h1c4a, 5'h10, 3'h0, 8'ha0, 8'he8};
    for (i = 0; i < 15; i = i + 1) begin
      start_run(rows[i]);
      repeat (40) @(posedge core_clk);
      mon <= 1'b0;
      #1;
      chk("row flags", {8'h00, rows[i][15:8] & rows[i][7:0]},
        {8'h00, seen & rows[i][7:0]});
    end
    // Reset values, then fetches with coprocessor and overlap on
    @(posedge core_clk);
    fp_present <= 1'b1;
    overlap_start <= 1'b1;
    start_run(rows[0]);
    #1;
    chk("tstate", 16'h0001, {12'h000, i_ofs_top.tstate});
    chk("ir reset", 16'h0000, i_ofs_top.instruction_register);
    chk("pc reset", 16'h0000, i_ofs_top.program_counter_copy);
    k = 0;
    while (i_ofs_top.instruction_register !== 16'h1042 && k < 40) begin
      @(posedge core_clk);
      #1;
      k = k + 1;
    end
    chk("ir", 16'h1042, i_ofs_top.instruction_register);
    chk("br", 16'h1042, i_ofs_top.bus_register);
    chk("pc", 16'h0002, i_ofs_top.program_counter_copy);
    k = 0;
    while (i_ofs_top.program_counter_copy !== 16'h0004 && k < 60) begin
      @(posedge core_clk);
      #1;
      k = k + 1;
    end
    chk("fp addr", 16'h0002,
      i_ofs_top.coprocessor_address_register);
    chk("fp word", 16'h1042,
      i_ofs_top.coprocessor_instruction_register);
    chk("overlap flags", 16'h0080, {8'h00, seen & 8'h88});
    wrap_up;
  end
endmodule
